//--- pkg/startup_pkg.sv
/*
 Constants for the start-up and reset strap sequencer.
 Assumes a 250 MHz system clock; used by the sequencer and its strap store.
*/
package startup_pkg;
  localparam int  CLK_PERIOD_PS      = 4000;
  localparam int  MIN_PD_PULSE_NS    = 200;
  // Least low time rounded up to whole cycles.
  localparam int  MIN_PD_PULSE_CYC   = (MIN_PD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int  CAL_CYCLES         = 64;
  localparam int  PLL_START_CYCLES   = 32;
  localparam int  CNT_W              = 16;
  // Three-level strap encoding.
  localparam logic [1:0] TRI_LOW     = 2'h0;
  localparam logic [1:0] TRI_MID     = 2'h1;
  localparam logic [1:0] TRI_HIGH    = 2'h2;
  localparam logic       IF_I2C      = 1'b0;
  localparam logic       IF_SPI      = 1'b1;
  localparam logic [3:0] PAGE_RESET  = 4'h0;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_POR,
    ST_WAIT_XO,
    ST_CAL,
    ST_PLL_START,
    ST_RUN
  } seq_state_type;
endpackage

//--- verif/host_model.sv
/*
 Host model: drives the power-down pin, the soft reset bit and the sync hold bit.
 Assumes one bench process calls its tasks, each starting at a clock edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic ref_clk,
  output logic      powerdown_bar_pin,
  output logic      soft_reset_bit,
  output logic      output_sync_hold_bit
);
  initial begin
    powerdown_bar_pin    = 1'b0;
    soft_reset_bit       = 1'b0;
    output_sync_hold_bit = 1'b0;
  end
  // The caller times the low phase; a hard reset needs more than 50 cycles.
  task automatic drop_pd();
    @(posedge ref_clk) powerdown_bar_pin <= 1'b0;
  endtask
  // The bench makes the oscillator valid before calibration can begin.
  task automatic release_pd();
    @(posedge ref_clk) powerdown_bar_pin <= 1'b1;
  endtask
  // Hold is set first so outputs cannot glitch while the PLLs restart.
  task automatic soft_restart();
    @(posedge ref_clk) output_sync_hold_bit <= 1'b1;
    @(posedge ref_clk) soft_reset_bit <= 1'b1;
    @(posedge ref_clk) soft_reset_bit <= 1'b0;
    @(posedge ref_clk) output_sync_hold_bit <= 1'b0;
  endtask
endmodule

//--- verif/startup_reset_strap_sequencer_bench.sv
/*
 Bench for the start-up sequencer: power-down, straps, pulses and soft reset.
 Assumes the host model drives the power-down pin and the soft reset controls.
*/
`timescale 1ns/1ps
module startup_reset_strap_sequencer_bench;
  import startup_pkg::*;
  logic       ref_clk, resetn, powerdown_bar_pin, supplies_good, xo_valid, interface_select_strap;
  logic [1:0] page_select_strap_lo, page_select_strap_hi, cs_addr_level, i2c_addr_select;
  logic       soft_reset_bit, output_sync_hold_bit, cal_done, sdata_in, spi_sdata_out, spi_sdata_oe;
  logic       i2c_sda_pull, sdata_out, sdata_oe, spi_select, spi_chip_select_n, serial_enable;
  logic       por_active, vco_cal_start, resonator_apll_enable, dpll_ref_validate_en;
  logic       outputs_enable, gpio_mode, in_reset;
  logic [3:0] startup_page;
  int         err_count = 0;
  int         samples_checked = 0;
  // Short calibration and start-up counts keep the run brief.
  startup_reset_strap_sequencer #(.CAL_LEN(8), .PLL_LEN(4)) startup_reset_strap_sequencer_i (
    .ref_clk(ref_clk), .resetn(resetn), .powerdown_bar_pin(powerdown_bar_pin),
    .supplies_good(supplies_good), .xo_valid(xo_valid), .interface_select_strap(interface_select_strap),
    .page_select_strap_lo(page_select_strap_lo), .page_select_strap_hi(page_select_strap_hi),
    .soft_reset_bit(soft_reset_bit), .output_sync_hold_bit(output_sync_hold_bit), .cal_done(cal_done),
    .cs_addr_level(cs_addr_level), .sdata_in(sdata_in), .spi_sdata_out(spi_sdata_out),
    .spi_sdata_oe(spi_sdata_oe), .i2c_sda_pull(i2c_sda_pull), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .spi_select(spi_select), .spi_chip_select_n(spi_chip_select_n), .i2c_addr_select(i2c_addr_select),
    .serial_enable(serial_enable), .por_active(por_active), .vco_cal_start(vco_cal_start),
    .resonator_apll_enable(resonator_apll_enable), .dpll_ref_validate_en(dpll_ref_validate_en),
    .outputs_enable(outputs_enable), .gpio_mode(gpio_mode), .startup_page(startup_page),
    .in_reset(in_reset));
  host_model host_model_i (.ref_clk(ref_clk), .powerdown_bar_pin(powerdown_bar_pin),
    .soft_reset_bit(soft_reset_bit), .output_sync_hold_bit(output_sync_hold_bit));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A bounded wait; a stuck sequence counts a mismatch rather than hanging the run.
  task automatic wait_run();
    for (int i = 0; i < 400 && gpio_mode !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("gpio_mode", 4'h1, gpio_mode);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pd_hold();
    @(posedge ref_clk) {supplies_good, xo_valid, interface_select_strap} <= 3'h7;
    page_select_strap_lo <= TRI_MID;
    page_select_strap_hi <= TRI_HIGH;
    {spi_sdata_oe, spi_sdata_out} <= 2'h3;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("serial_enable", 4'h0, serial_enable);
    chk("outputs_enable", 4'h0, outputs_enable);
    chk("sdata_oe", 4'h0, sdata_oe);
    chk("in_reset", 4'h1, in_reset);
    chk("por_active", 4'h1, por_active);
  endtask
  task automatic t_spi_up();
    host_model_i.release_pd();
    wait_run();
    chk("serial_enable", 4'h1, serial_enable);
    chk("outputs_enable", 4'h1, outputs_enable);
    chk("spi_select", 4'h1, spi_select);
    chk("startup_page", 4'h9, startup_page);
    chk("spi_chip_select_n", 4'h0, spi_chip_select_n);
    chk("sdata_oe", 4'h1, sdata_oe);
    chk("sdata_out", 4'h1, sdata_out);
    chk("dpll_ref_validate_en", 4'h1, dpll_ref_validate_en);
    chk("resonator_apll_enable", 4'h1, resonator_apll_enable);
    chk("por_active", 4'h0, por_active);
  endtask
  task automatic t_pulses();
    host_model_i.drop_pd();
    repeat (20) @(posedge ref_clk);
    #1;
    chk("gpio_mode", 4'h1, gpio_mode);
    host_model_i.release_pd();
    repeat (10) @(posedge ref_clk);
    #1;
    chk("gpio_mode", 4'h1, gpio_mode);
  endtask
  task automatic t_soft();
    @(posedge ref_clk) {interface_select_strap, xo_valid} <= 2'h0;
    page_select_strap_lo <= TRI_LOW;
    page_select_strap_hi <= TRI_LOW;
    fork
      host_model_i.soft_restart();
      begin
        @(posedge ref_clk);
        #1;
        chk("outputs_enable", 4'h0, outputs_enable);
      end
    join
    repeat (10) @(posedge ref_clk);
    #1;
    chk("gpio_mode", 4'h0, gpio_mode);
    chk("vco_cal_start", 4'h0, vco_cal_start);
    chk("dpll_ref_validate_en", 4'h0, dpll_ref_validate_en);
    chk("resonator_apll_enable", 4'h0, resonator_apll_enable);
    @(posedge ref_clk) xo_valid <= 1'b1;
    for (int i = 0; i < 50 && vco_cal_start !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("vco_cal_start", 4'h1, vco_cal_start);
    wait_run();
    chk("spi_select", 4'h1, spi_select);
    chk("startup_page", 4'h9, startup_page);
  endtask
  task automatic t_i2c_up();
    @(posedge ref_clk) {supplies_good, i2c_sda_pull} <= 2'h1;
    cs_addr_level <= 2'h2;
    page_select_strap_hi <= TRI_MID;
    host_model_i.drop_pd();
    repeat (60) @(posedge ref_clk);
    #1;
    chk("in_reset", 4'h1, in_reset);
    host_model_i.release_pd();
    repeat (20) @(posedge ref_clk);
    #1;
    chk("in_reset", 4'h1, in_reset);
    chk("serial_enable", 4'h0, serial_enable);
    chk("por_active", 4'h1, por_active);
    @(posedge ref_clk) supplies_good <= 1'b1;
    cal_done <= 1'b1;
    wait_run();
    chk("spi_select", 4'h0, spi_select);
    chk("startup_page", 4'h4, startup_page);
    chk("i2c_addr_select", 4'h2, i2c_addr_select);
    chk("spi_chip_select_n", 4'h1, spi_chip_select_n);
    chk("sdata_oe", 4'h1, sdata_oe);
    chk("sdata_out", 4'h0, sdata_out);
    host_model_i.soft_restart();
    wait_run();
    chk("spi_select", 4'h0, spi_select);
    chk("startup_page", 4'h4, startup_page);
    chk("outputs_enable", 4'h1, outputs_enable);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {resetn, supplies_good, xo_valid, interface_select_strap, cal_done, sdata_in} = 6'h00;
    {spi_sdata_out, spi_sdata_oe, i2c_sda_pull} = 3'h0;
    {page_select_strap_lo, page_select_strap_hi, cs_addr_level} = 6'h00;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_pd_hold();
    t_spi_up();
    t_pulses();
    t_soft();
    t_i2c_up();
    results();
  end
endmodule

//--- verilog/startup_reset_strap_sequencer.sv
/*
 Start-up and reset sequencer of a clock synchronizer.
 Assumes a 250 MHz system clock; analog supply and oscillator monitors arrive as synchronous levels.
*/
// Function
// - Power-down low keeps every function off, vco_cal_start only from one cycle later, and the serial port silent.
// - Power-down release starts power-on reset, then start-up, then normal operation.
// - Low pulses longer than 200 ns are caught as a hard reset.
// - Interface strap sampled at power-on reset: high SPI, low I2C, kept.
// - Page straps read as three-level at reset; afterwards pins are GPIO.
// - Chip-select pin is SPI select or three-level I2C address input.
// - Data pin serves SPI or I2C as strapped.
// - Reset held until core supplies and power-down pin are above threshold.
// - Soft reset re-runs VCO calibration and PLL start-up.
// - Resonator PLL locks on valid oscillator; paired DPLL validates after it.
`timescale 1ns/1ps
module startup_reset_strap_sequencer
  import startup_pkg::*;
#(
  parameter int CAL_LEN = CAL_CYCLES,
  parameter int PLL_LEN = PLL_START_CYCLES
)(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       powerdown_bar_pin,
  input  wire logic       supplies_good,
  input  wire logic       xo_valid,
  input  wire logic       interface_select_strap,
  input  wire logic [1:0] page_select_strap_lo,
  input  wire logic [1:0] page_select_strap_hi,
  input  wire logic       soft_reset_bit,
  input  wire logic       output_sync_hold_bit,
  input  wire logic       cal_done,
  input  wire logic [1:0] cs_addr_level,
  input  wire logic       sdata_in,
  input  wire logic       spi_sdata_out,
  input  wire logic       spi_sdata_oe,
  input  wire logic       i2c_sda_pull,
  output logic            sdata_out,
  output logic            sdata_oe,
  output logic            spi_select,
  output logic            spi_chip_select_n,
  output logic [1:0]      i2c_addr_select,
  output logic            serial_enable,
  output logic            por_active,
  output logic            vco_cal_start,
  output logic            resonator_apll_enable,
  output logic            dpll_ref_validate_en,
  output logic            outputs_enable,
  output logic            gpio_mode,
  output logic [3:0]      startup_page,
  output logic            in_reset
);
  // ------------------------------------------------------------
  // Power-down synchronizer and pulse qualification
  // ------------------------------------------------------------
  logic          pd_meta_reg;
  logic          pd_sync_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic          pd_low_reg;
  seq_state_type state_reg;
  logic [CNT_W-1:0] tmr_reg;
  logic          soft_d_reg;
  logic          capture;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pd_meta_reg <= 1'b0;
      pd_sync_reg <= 1'b0;
    end else begin
      pd_meta_reg <= powerdown_bar_pin;
      pd_sync_reg <= pd_meta_reg;
    end
  end

  // A low shorter than the minimum is ignored; a longer one latches power-down.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      low_cnt_reg <= '0;
      pd_low_reg  <= 1'b1;
    end else if (pd_sync_reg) begin
      low_cnt_reg <= '0;
      pd_low_reg  <= 1'b0;
    end else if (low_cnt_reg >= CNT_W'(MIN_PD_PULSE_CYC)) begin
      pd_low_reg  <= 1'b1;
    end else begin
      low_cnt_reg <= low_cnt_reg + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Start-up sequence
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      soft_d_reg <= 1'b0;
    end else begin
      soft_d_reg <= soft_reset_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
      tmr_reg   <= '0;
    end else if (pd_low_reg) begin
      state_reg <= ST_OFF;
      tmr_reg   <= '0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_POR;
        end
        ST_POR: begin
          if (supplies_good) begin
            state_reg <= ST_WAIT_XO;
          end
        end
        ST_WAIT_XO: begin
          tmr_reg <= '0;
          if (xo_valid) begin
            state_reg <= ST_CAL;
          end
        end
        ST_CAL: begin
          tmr_reg <= tmr_reg + CNT_W'(1);
          if (cal_done || tmr_reg >= CNT_W'(CAL_LEN - 1)) begin
            state_reg <= ST_PLL_START;
            tmr_reg   <= '0;
          end
        end
        ST_PLL_START: begin
          tmr_reg <= tmr_reg + CNT_W'(1);
          if (tmr_reg >= CNT_W'(PLL_LEN - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (soft_reset_bit && !soft_d_reg) begin
            state_reg <= ST_WAIT_XO;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // Straps are caught only in the power-on phase, never on soft reset.
  assign capture = (state_reg == ST_POR) && supplies_good;

  strap_store strap_store_i (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .capture      (capture),
    .if_strap     (interface_select_strap),
    .page_lo      (page_select_strap_lo),
    .page_hi      (page_select_strap_hi),
    .spi_mode_reg (spi_select),
    .page_reg     (startup_page)
  );

  // ------------------------------------------------------------
  // Outputs and pin roles
  // ------------------------------------------------------------
  logic running;
  logic cfg_ok;
  // Gating with the latched power-down closes the one-cycle gap before the state falls back to off.
  assign running    = (state_reg == ST_RUN) && !pd_low_reg;
  assign cfg_ok     = (state_reg != ST_OFF) && (state_reg != ST_POR) && !pd_low_reg;
  assign serial_enable = cfg_ok;
  assign por_active = (state_reg == ST_POR) || (state_reg == ST_OFF);
  assign in_reset   = !running;
  assign vco_cal_start = (state_reg == ST_CAL);
  assign resonator_apll_enable = cfg_ok && xo_valid;
  assign dpll_ref_validate_en  = running && xo_valid;
  // Holding sync keeps outputs muted so the host can align them after restart.
  assign outputs_enable = running && !output_sync_hold_bit;
  assign gpio_mode  = running;
  assign spi_chip_select_n = (cfg_ok && spi_select) ? cs_addr_level[0] : 1'b1;
  assign i2c_addr_select   = (cfg_ok && !spi_select) ? cs_addr_level : TRI_LOW;
  // I2C drives only low (open drain); SPI drives its own data when asked.
  always_comb begin
    sdata_out = 1'b0;
    sdata_oe  = 1'b0;
    if (cfg_ok) begin
      if (spi_select) begin
        sdata_out = spi_sdata_out;
        sdata_oe  = spi_sdata_oe;
      end else begin
        sdata_out = 1'b0;
        sdata_oe  = i2c_sda_pull;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic unused_in;
  assign unused_in = sdata_in;

  powerdown_silent_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pd_low_reg |-> !serial_enable && !outputs_enable && !sdata_oe)
    else $error("Serial port active during power-down.");
  release_starts_por_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_OFF && !pd_low_reg) |=> state_reg == ST_POR)
    else $error("Power-down release did not start reset.");
  short_pulse_ignored_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ($rose(pd_low_reg)) |-> $past(pd_sync_reg, 51) == 1'b0)
    else $error("Power-down latched on a short low pulse.");
  strap_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg != ST_POR) |=> $stable(spi_select) && $stable(startup_page))
    else $error("Straps changed outside power-on reset.");
  gpio_after_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    gpio_mode |-> state_reg == ST_RUN)
    else $error("GPIO mode before normal operation.");
  cs_role_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg_ok && !spi_select) |-> spi_chip_select_n && i2c_addr_select == cs_addr_level)
    else $error("Chip-select pin role wrong for I2C.");
  i2c_no_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!spi_select && sdata_oe) |-> !sdata_out)
    else $error("I2C data driven high.");
  supply_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_POR && !supplies_good) |=> state_reg != ST_WAIT_XO)
    else $error("Reset left with supplies low.");
  soft_recal_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (running && soft_reset_bit && !soft_d_reg && !pd_low_reg && xo_valid) |=> ##1 vco_cal_start)
    else $error("Soft reset did not recalibrate.");
  dpll_after_xo_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    dpll_ref_validate_en |-> xo_valid && resonator_apll_enable)
    else $error("DPLL validated before oscillator.");
  sync_first_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pd_meta_reg != pd_sync_reg |=> pd_sync_reg == $past(pd_meta_reg))
    else $error("Synchronizer stage skipped.");
  no_soft_capture_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_WAIT_XO) |-> !capture)
    else $error("Straps resampled on soft reset.");

  reach_run_c: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(running));
  soft_reset_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    running && soft_reset_bit && !soft_d_reg);
  hard_reset_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_RUN) && $rose(pd_low_reg));
endmodule

//--- verilog/strap_store.sv
/*
 Strap store: latches the interface and page straps on a capture strobe.
 Assumes strap inputs are synchronous and stable while the capture strobe is high.
*/
`timescale 1ns/1ps
module strap_store
  import startup_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       capture,
  input  wire logic       if_strap,
  input  wire logic [1:0] page_lo,
  input  wire logic [1:0] page_hi,
  output logic            spi_mode_reg,
  output logic [3:0]      page_reg
);
  // Only a power-on capture writes here, so soft reset keeps the choices.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      spi_mode_reg <= IF_I2C;
      page_reg     <= PAGE_RESET;
    end else if (capture) begin
      spi_mode_reg <= if_strap;
      page_reg     <= {page_hi, page_lo};
    end
  end
endmodule
